/* design/xsp_pkg.sv */
// Function
// - Muxed low address/data bus, configurable high byte
// - Enabled port overrides dedicated pin directions
// - Port decides internal or external per access
// - Low address valid when latch strobe falls
// - Latch strobe low through whole data phase
// - Internal accesses never toggle read/write strobes
// - Disabled port: high addresses never alias internally
// - Port bits written one enable bus pull-ups
// - Bus-keeper holds level when bus tri-stated
// - Two-bit wait code, zero means no waits
// - Trailing latch pulse in T4 to T7
// - Trailing pulse only when next access RAM
// - Upper and lower sectors with own waits
// - Upper sector field one, lower field zero; the code takes upper from CTRL_A bits 1:0, lower from bits 3:2
// - Normal mode: external from 0x1100 upward
// - Address output untranslated, top bit aliasing
// - Legacy mode: external from 0x1000 upward
// - Legacy: zero or one wait, fixed width, no keeper
// - Mask field releases top high-address pins
package xsp_pkg;

  // Register word indices on the bus
  localparam logic [2:0] XSP_REG_CORE = 3'h0;
  localparam logic [2:0] XSP_REG_CTRL_A = 3'h1;
  localparam logic [2:0] XSP_REG_CTRL_B = 3'h2;
  localparam logic [2:0] XSP_REG_AD_PORT = 3'h3;
  localparam logic [2:0] XSP_REG_AD_DIR = 3'h4;
  localparam logic [2:0] XSP_REG_HI_PORT = 3'h5;
  localparam logic [2:0] XSP_REG_HI_DIR = 3'h6;
  localparam logic [2:0] XSP_REG_STATUS = 3'h7;

  // Field positions
  localparam int XSP_CORE_EN_BIT = 7;
  localparam int XSP_CORE_WAIT_BIT = 6;
  localparam int XSP_CTRLA_UPPER_LSB = 0;
  localparam int XSP_CTRLA_LOWER_LSB = 2;
  localparam int XSP_CTRLA_LIMIT_LSB = 4;
  localparam int XSP_CTRLB_KEEP_BIT = 7;
  localparam int XSP_CTRLB_MASK_LSB = 0;
  localparam int XSP_SECTOR_SHIFT = 13;

  // Reset values
  localparam logic [7:0] XSP_REG_RST = 8'h00;
  localparam logic [15:0] XSP_ADDR_RST = 16'h0000;

  // Internal space tops
  localparam logic [15:0] XSP_INT_TOP_NORMAL = 16'h10ff;
  localparam logic [15:0] XSP_INT_TOP_LEGACY = 16'h0fff;

  // Strap wait in clock periods, synchroniser width in bits
  localparam logic [1:0] XSP_STRAP_CYCLES = 2'h2;
  localparam int XSP_SYNC_W = 9;

  typedef struct packed {
    logic valid;
    logic we;
    logic next_ram;
    logic [15:0] addr;
    logic [7:0] wdata;
  } xsp_cpu_req_t;

  typedef struct packed {
    logic ack;
    logic ext;
    logic unmapped;
    logic [7:0] rdata;
  } xsp_cpu_rsp_t;

  typedef struct packed {
    logic [7:0] ad_out;
    logic [7:0] ad_oe;
    logic [7:0] ad_pullup;
    logic keep_en;
    logic [7:0] keep_val;
    logic [7:0] high_out;
    logic [7:0] high_oe;
    logic ale;
    logic rd_n;
    logic wr_n;
  } xsp_pads_t;

  localparam xsp_pads_t XSP_PADS_RST = '{ad_out: 8'h00, ad_oe: 8'h00, ad_pullup: 8'h00, keep_en: 1'b0,
    keep_val: 8'h00, high_out: 8'h00, high_oe: 8'h00, ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1};

  localparam xsp_cpu_rsp_t XSP_RSP_RST = '{ack: 1'b0, ext: 1'b0, unmapped: 1'b0, rdata: 8'h00};

  typedef enum logic [4:0] {
    XSP_ST_IDLE = 5'h01,
    XSP_ST_ADDR = 5'h02,
    XSP_ST_HOLD = 5'h04,
    XSP_ST_STROBE = 5'h08,
    XSP_ST_TRAIL = 5'h10
  } xsp_state_t;

endpackage

/* design/xsp_port.sv */
// The address map and the Avalon-MM slave port were chosen for this implementation.
module xsp_port (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register bus
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // CPU data access
  input wire xsp_pkg::xsp_cpu_req_t cpu_req,
  output xsp_pkg::xsp_cpu_rsp_t cpu_rsp,
  // Pins
  input wire logic [7:0] ad_in,
  input wire logic compat_strap,
  output xsp_pkg::xsp_pads_t pads
);
  import xsp_pkg::*;

  logic [XSP_SYNC_W-1:0] sync_q;
  logic [7:0] core_ff;
  logic [7:0] ctrl_a_ff;
  logic [7:0] ctrl_b_ff;
  logic [7:0] ad_port_ff;
  logic [7:0] ad_dir_ff;
  logic [7:0] hi_port_ff;
  logic [7:0] hi_dir_ff;
  logic compat_ff;
  logic strap_done_ff;
  logic [1:0] strap_cnt_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [15:0] rd_mux;
  xsp_state_t state_ff;
  xsp_state_t nxt_state;
  xsp_cpu_req_t req_ff;
  logic ext_ff;
  logic [1:0] wcode_ff;
  logic [1:0] cnt_ff;
  logic [1:0] fetch_dly_ff;
  xsp_cpu_rsp_t rsp_ff;
  xsp_pads_t pads_ff;
  xsp_pads_t nxt_pads;
  logic port_en;
  logic take;
  logic bus_req;
  logic bus_commit;
  logic [7:0] released;

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign cpu_rsp = rsp_ff;
  assign pads = pads_ff;

  // Pins and the strap come from outside the clock domain
  xsp_sync u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({compat_strap, ad_in}),
    .q(sync_q)
  );

  function automatic logic is_external(input logic [15:0] addr, input logic legacy);
    logic [15:0] top;
    top = legacy ? XSP_INT_TOP_LEGACY : XSP_INT_TOP_NORMAL;
    return addr > top;
  endfunction

  function automatic logic [1:0] wait_for(input logic [15:0] addr, input logic legacy,
                                          input logic [7:0] ctrl_a, input logic [7:0] core);
    logic [2:0] limit;
    logic [15:0] bound;
    limit = ctrl_a[XSP_CTRLA_LIMIT_LSB +: 3];
    bound = 16'(limit) << XSP_SECTOR_SHIFT;
    if (legacy) begin
      return {1'b0, core[XSP_CORE_WAIT_BIT]};
    end else if (limit != 3'h0 && addr < bound) begin
      return ctrl_a[XSP_CTRLA_LOWER_LSB +: 2];
    end else begin
      return ctrl_a[XSP_CTRLA_UPPER_LSB +: 2];
    end
  endfunction

  // High pins handed back to the port, counted from the top
  function automatic logic [7:0] high_release(input logic [2:0] n);
    return ~(8'hff >> n);
  endfunction

  assign port_en = core_ff[XSP_CORE_EN_BIT];
  assign bus_req = avs_read | avs_write;
  assign bus_commit = avs_write & ~wait_ff;
  // A read still waiting for its pin data counts as busy, or the held request would be taken twice
  assign take = (state_ff == XSP_ST_IDLE) & cpu_req.valid & ~rsp_ff.ack & strap_done_ff & (fetch_dly_ff == 2'h0);
  assign released = compat_ff ? 8'h00 : high_release(ctrl_b_ff[XSP_CTRLB_MASK_LSB +: 3]);

  // Strap is taken only once the synchroniser has filled after reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt_ff <= 2'h0;
      strap_done_ff <= 1'b0;
      compat_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      if (strap_cnt_ff == XSP_STRAP_CYCLES) begin
        strap_done_ff <= 1'b1;
        compat_ff <= sync_q[8];
      end else begin
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
      end
    end
  end

  // One wait cycle per access, then the answer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= ~(bus_req & wait_ff);
    end
  end

  always_comb begin
    rd_mux = 16'h0000;
    if (avs_address == XSP_REG_CORE) begin
      rd_mux = {8'h00, core_ff};
    end else if (avs_address == XSP_REG_CTRL_A) begin
      rd_mux = {8'h00, ctrl_a_ff};
    end else if (avs_address == XSP_REG_CTRL_B) begin
      rd_mux = {8'h00, ctrl_b_ff};
    end else if (avs_address == XSP_REG_AD_PORT) begin
      rd_mux = {8'h00, ad_port_ff};
    end else if (avs_address == XSP_REG_AD_DIR) begin
      rd_mux = {8'h00, ad_dir_ff};
    end else if (avs_address == XSP_REG_HI_PORT) begin
      rd_mux = {8'h00, hi_port_ff};
    end else if (avs_address == XSP_REG_HI_DIR) begin
      rd_mux = {8'h00, hi_dir_ff};
    end else if (avs_address == XSP_REG_STATUS) begin
      rd_mux = {sync_q[7:0], 4'h0, rsp_ff.unmapped, rsp_ff.ext, compat_ff, state_ff != XSP_ST_IDLE};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read & wait_ff) begin
      rdata_ff <= {16'h0000, rd_mux};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      core_ff <= XSP_REG_RST;
      ad_port_ff <= XSP_REG_RST;
      ad_dir_ff <= XSP_REG_RST;
      hi_port_ff <= XSP_REG_RST;
      hi_dir_ff <= XSP_REG_RST;
    end else if (bus_commit) begin
      if (avs_address == XSP_REG_CORE) begin
        core_ff <= avs_writedata[7:0];
      end else if (avs_address == XSP_REG_AD_PORT) begin
        ad_port_ff <= avs_writedata[7:0];
      end else if (avs_address == XSP_REG_AD_DIR) begin
        ad_dir_ff <= avs_writedata[7:0];
      end else if (avs_address == XSP_REG_HI_PORT) begin
        hi_port_ff <= avs_writedata[7:0];
      end else if (avs_address == XSP_REG_HI_DIR) begin
        hi_dir_ff <= avs_writedata[7:0];
      end
    end
  end

  // Extended control registers do not exist in legacy mode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a_ff <= XSP_REG_RST;
      ctrl_b_ff <= XSP_REG_RST;
    end else if (bus_commit & ~compat_ff) begin
      if (avs_address == XSP_REG_CTRL_A) begin
        ctrl_a_ff <= avs_writedata[7:0];
      end else if (avs_address == XSP_REG_CTRL_B) begin
        ctrl_b_ff <= avs_writedata[7:0];
      end
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      XSP_ST_IDLE: begin
        if (take && port_en) begin
          nxt_state = XSP_ST_ADDR;
        end
      end
      XSP_ST_ADDR: begin
        nxt_state = XSP_ST_HOLD;
      end
      XSP_ST_HOLD: begin
        nxt_state = ext_ff ? XSP_ST_STROBE : XSP_ST_IDLE;
      end
      XSP_ST_STROBE: begin
        if (cnt_ff == wcode_ff) begin
          nxt_state = XSP_ST_TRAIL;
        end
      end
      XSP_ST_TRAIL: begin
        nxt_state = XSP_ST_IDLE;
      end
      default: begin
        nxt_state = XSP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= XSP_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      req_ff <= '0;
      ext_ff <= 1'b0;
      wcode_ff <= 2'h0;
    end else if (take) begin
      req_ff <= cpu_req;
      ext_ff <= is_external(cpu_req.addr, compat_ff);
      wcode_ff <= wait_for(cpu_req.addr, compat_ff, ctrl_a_ff, core_ff);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 2'h0;
    end else if (state_ff == XSP_ST_STROBE) begin
      cnt_ff <= cnt_ff + 2'h1;
    end else begin
      cnt_ff <= 2'h0;
    end
  end

  // The pin capture runs two edges behind the bus; a read answer waits for it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fetch_dly_ff <= 2'h0;
    end else begin
      fetch_dly_ff <= {fetch_dly_ff[0], (state_ff == XSP_ST_STROBE) & (nxt_state == XSP_ST_TRAIL) & ~req_ff.we};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rsp_ff <= XSP_RSP_RST;
    end else begin
      rsp_ff.ack <= 1'b0;
      if (take && !port_en) begin
        rsp_ff.ack <= 1'b1;
        rsp_ff.ext <= 1'b0;
        rsp_ff.unmapped <= is_external(cpu_req.addr, compat_ff);
        rsp_ff.rdata <= 8'h00;
      end else if (state_ff == XSP_ST_HOLD && !ext_ff) begin
        rsp_ff.ack <= 1'b1;
        rsp_ff.ext <= 1'b0;
        rsp_ff.unmapped <= 1'b0;
        rsp_ff.rdata <= 8'h00;
      end else if (state_ff == XSP_ST_TRAIL && req_ff.we) begin
        rsp_ff.ack <= 1'b1;
        rsp_ff.ext <= 1'b1;
        rsp_ff.unmapped <= 1'b0;
      end else if (fetch_dly_ff[1]) begin
        rsp_ff.ack <= 1'b1;
        rsp_ff.ext <= 1'b1;
        rsp_ff.unmapped <= 1'b0;
        rsp_ff.rdata <= sync_q[7:0];
      end
    end
  end

  always_comb begin
    nxt_pads = XSP_PADS_RST;
    if (port_en) begin
      // High byte carries the raw data-space address; masked pins fall back to the port
      nxt_pads.high_out = (req_ff.addr[15:8] & ~released) | (hi_port_ff & released);
      nxt_pads.high_oe = ~released | (hi_dir_ff & released);
      case (nxt_state)
        XSP_ST_ADDR: begin
          nxt_pads.ad_out = take ? cpu_req.addr[7:0] : req_ff.addr[7:0];
          nxt_pads.ad_oe = 8'hff;
          nxt_pads.ale = 1'b1;
          nxt_pads.high_out = ((take ? cpu_req.addr[15:8] : req_ff.addr[15:8]) & ~released)
                              | (hi_port_ff & released);
        end
        XSP_ST_HOLD: begin
          nxt_pads.ad_out = req_ff.addr[7:0];
          nxt_pads.ad_oe = 8'hff;
        end
        XSP_ST_STROBE: begin
          nxt_pads.ad_out = req_ff.wdata;
          nxt_pads.ad_oe = req_ff.we ? 8'hff : 8'h00;
          nxt_pads.rd_n = req_ff.we;
          nxt_pads.wr_n = ~req_ff.we;
        end
        XSP_ST_TRAIL: begin
          nxt_pads.ad_out = req_ff.wdata;
          nxt_pads.ad_oe = req_ff.we ? 8'hff : 8'h00;
          nxt_pads.ale = req_ff.next_ram;
        end
        default: begin
          // Keep the last value so a trailing latch pulse falls on a steady bus
          nxt_pads.ad_out = pads_ff.ad_out;
          nxt_pads.ad_oe = 8'h00;
        end
      endcase
      nxt_pads.keep_en = ctrl_b_ff[XSP_CTRLB_KEEP_BIT] & ~compat_ff & (nxt_pads.ad_oe == 8'h00);
    end else begin
      nxt_pads.ad_out = ad_port_ff;
      nxt_pads.ad_oe = ad_dir_ff;
      nxt_pads.high_out = hi_port_ff;
      nxt_pads.high_oe = hi_dir_ff;
    end
    nxt_pads.ad_pullup = ad_port_ff & ~nxt_pads.ad_oe;
    // Keeper holds the last level seen: driven value, or data fetched from memory
    if (nxt_pads.ad_oe == 8'hff) begin
      nxt_pads.keep_val = nxt_pads.ad_out;
    end else if (fetch_dly_ff[1]) begin
      nxt_pads.keep_val = sync_q[7:0];
    end else begin
      nxt_pads.keep_val = pads_ff.keep_val;
    end
  end

  // ALE is low in HOLD, STROBE and the non-pulsed trail, so it spans the data phase
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pads_ff <= XSP_PADS_RST;
    end else begin
      pads_ff <= nxt_pads;
    end
  end

endmodule

/* design/xsp_sync.sv */
module xsp_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Asynchronous levels in, synchronised levels out
  input wire logic [xsp_pkg::XSP_SYNC_W-1:0] d,
  output logic [xsp_pkg::XSP_SYNC_W-1:0] q
);
  import xsp_pkg::*;

  logic [XSP_SYNC_W-1:0] meta_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end

endmodule

/* test/tb_xsp_port.sv */
module tb_xsp_port;
  timeunit 1ns;
  timeprecision 1ns;
  import xsp_pkg::*;
  `define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
    $display("FAIL %s expected %h seen %h", nm, exp, got); end end
  logic clock;
  logic rst_n;
  logic [2:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  xsp_cpu_req_t cpu_req;
  xsp_cpu_rsp_t cpu_rsp;
  logic [7:0] ad_in;
  logic [7:0] ad_last = 8'h00;
  logic compat_strap;
  xsp_pads_t pads;
  logic [7:0] mem_d;
  logic mem_oe;
  logic [31:0] q;
  int lat;
  int n_fail;
  int comparisons;
  xsp_port dut (.clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp), .ad_in(ad_in),
    .compat_strap(compat_strap), .pads(pads));
  xsp_sram_model mem0 (.pads(pads), .mem_d(mem_d), .mem_oe(mem_oe));
  // Released lines drift to the inverse of their last level unless pulled or kept
  assign ad_in = mem_oe ? mem_d : (pads.ad_oe & pads.ad_out)
    | (~pads.ad_oe & (pads.keep_en ? pads.keep_val : (pads.ad_pullup | ~ad_last)));
  always @(posedge clock) ad_last <= ad_in;
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic reg_rw(input logic w, input logic [2:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic acc(input logic we, input logic [15:0] a, input logic [7:0] d, input logic nr);
    cpu_req <= '{valid: 1'b1, we: we, next_ram: nr, addr: a, wdata: d};
    lat = -1;
    do begin
      @(posedge clock);
      lat++;
    end while (cpu_rsp.ack !== 1'b1);
    cpu_req.valid <= 1'b0;
    @(posedge clock);
  endtask
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    n_fail++;
    test_done;
  end
  initial begin
    n_fail = 0;
    comparisons = 0;
    rst_n = 1'b0;
    avs_address = 3'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    cpu_req = '0;
    compat_strap = 1'b0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    // Port disabled: pins follow their own registers
    reg_rw(1'b1, XSP_REG_AD_PORT, 8'ha5);
    reg_rw(1'b1, XSP_REG_AD_DIR, 8'h0f);
    // Pins follow a register write one edge later
    @(posedge clock);
    `CHK("ad_oe", 8'h0f, pads.ad_oe)
    `CHK("ad_out", 8'ha5, pads.ad_out)
    `CHK("ad_pullup", 8'ha0, pads.ad_pullup)
    reg_rw(1'b0, XSP_REG_CORE, 8'h00);
    `CHK("core", 32'h0, q)
    acc(1'b0, 16'h2000, 8'h00, 1'b0);
    `CHK("unmapped", 1'b1, cpu_rsp.unmapped)
    // Lower sector below 0x2000 with no waits, upper sector code 11
    reg_rw(1'b1, XSP_REG_CORE, 8'h80);
    reg_rw(1'b1, XSP_REG_CTRL_A, 8'h13);
    acc(1'b0, 16'h10ff, 8'h00, 1'b1);
    `CHK("ext 10ff", 1'b0, cpu_rsp.ext)
    `CHK("int lat", 3, lat)
    acc(1'b1, 16'h1100, 8'h3c, 1'b1);
    `CHK("ext 1100", 1'b1, cpu_rsp.ext)
    `CHK("lower wr lat", 5, lat)
    acc(1'b1, 16'h9234, 8'hc3, 1'b0);
    `CHK("upper wr lat", 8, lat)
    acc(1'b0, 16'h1234, 8'h00, 1'b1);
    `CHK("alias rdata", 8'hc3, cpu_rsp.rdata)
    `CHK("lower rd lat", 6, lat)
    acc(1'b0, 16'h1100, 8'h00, 1'b0);
    `CHK("rdata 1100", 8'h3c, cpu_rsp.rdata)
    for (int w = 0; w < 4; w++) begin
      reg_rw(1'b1, XSP_REG_CTRL_A, 8'(w));
      acc(1'b1, 16'h4000 + 16'(w), 8'h50 + 8'(w), 1'b1);
      `CHK("wr lat", 5 + w, lat)
      acc(1'b0, 16'h4000 + 16'(w), 8'h00, 1'b1);
      `CHK("rd lat", 6 + w, lat)
      `CHK("rdata", 8'h50 + 8'(w), cpu_rsp.rdata)
    end
    // Keeper on; top three high lines handed back to the port at zero
    reg_rw(1'b1, XSP_REG_HI_PORT, 8'h00);
    reg_rw(1'b1, XSP_REG_HI_DIR, 8'hff);
    reg_rw(1'b1, XSP_REG_CTRL_B, 8'h83);
    @(posedge clock);
    `CHK("keep_en", 1'b1, pads.keep_en)
    acc(1'b1, 16'he001, 8'h77, 1'b1);
    reg_rw(1'b1, XSP_REG_CTRL_B, 8'h80);
    acc(1'b0, 16'h8001, 8'h00, 1'b1);
    `CHK("mask rdata", 8'h77, cpu_rsp.rdata)
    `CHK("keep_val", 8'h77, pads.keep_val)
    // Legacy strap is caught only after a reset
    compat_strap <= 1'b1;
    rst_n <= 1'b0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    reg_rw(1'b1, XSP_REG_CORE, 8'h80);
    reg_rw(1'b1, XSP_REG_CTRL_A, 8'h33);
    reg_rw(1'b0, XSP_REG_CTRL_A, 8'h00);
    `CHK("legacy ctrl_a", 32'h0, q)
    acc(1'b0, 16'h0fff, 8'h00, 1'b1);
    `CHK("ext 0fff", 1'b0, cpu_rsp.ext)
    acc(1'b1, 16'h1000, 8'h11, 1'b0);
    `CHK("ext 1000", 1'b1, cpu_rsp.ext)
    `CHK("legacy lat", 5, lat)
    reg_rw(1'b0, XSP_REG_STATUS, 8'h00);
    `CHK("status", 8'h06, q[7:0])
    reg_rw(1'b1, XSP_REG_CORE, 8'hc0);
    acc(1'b1, 16'h1001, 8'h22, 1'b0);
    `CHK("legacy wait lat", 6, lat)
    test_done;
  end
endmodule

/* test/xsp_port_asserts.sv */
module xsp_port_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Watched ports
  input wire xsp_pkg::xsp_cpu_req_t cpu_req,
  input wire xsp_pkg::xsp_cpu_rsp_t cpu_rsp,
  input wire xsp_pkg::xsp_pads_t pads
);
  import xsp_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic strobe_seen_ff;
  // Remembers any strobe since the last answer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strobe_seen_ff <= 1'b0;
    end else if (cpu_rsp.ack) begin
      strobe_seen_ff <= 1'b0;
    end else if (!pads.rd_n || !pads.wr_n) begin
      strobe_seen_ff <= 1'b1;
    end
  end
  chk_strobe_excl: assert property (!(!pads.rd_n && !pads.wr_n))
    else $error("read and write strobes low together");
  chk_strobe_late: assert property (($fell(pads.rd_n) || $fell(pads.wr_n))
    |-> !pads.ale && !$past(pads.ale) && $past(pads.ale, 2)) else $error("strobe not one cycle after latch fall");
  chk_ale_data: assert property ((!pads.rd_n || !pads.wr_n) |-> !pads.ale)
    else $error("latch strobe high during transfer");
  chk_addr_hold: assert property ($fell(pads.ale) |-> pads.ad_out == $past(pads.ad_out))
    else $error("low address moved as latch strobe fell");
  chk_read_float: assert property (!pads.rd_n |-> pads.ad_oe == 8'h00)
    else $error("bus driven during read strobe");
  chk_write_drive: assert property (!pads.wr_n |-> pads.ad_oe == 8'hff)
    else $error("bus not driven during write strobe");
  chk_int_quiet: assert property (cpu_rsp.ack && !cpu_rsp.ext |-> !strobe_seen_ff)
    else $error("strobe during internal access");
  chk_strobe_len: assert property ($fell(pads.wr_n) |-> ##[1:4] $rose(pads.wr_n))
    else $error("write strobe too long");
  chk_trail_ale: assert property (($rose(pads.rd_n) || $rose(pads.wr_n))
    |-> pads.ale == $past(cpu_req.next_ram)) else $error("trailing latch pulse wrong");
endmodule

bind xsp_port xsp_port_asserts u_chk (.clock(clock), .rst_n(rst_n), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp), .pads(pads));

/* test/xsp_sram_model.sv */
module xsp_sram_model (
  // Port pins
  input wire xsp_pkg::xsp_pads_t pads,
  // Data driven back during reads
  output logic [7:0] mem_d,
  output logic mem_oe
);
  import xsp_pkg::*;
  logic [7:0] lat_q;
  logic [7:0] wbuf;
  logic [14:0] wadr;
  logic [14:0] a;
  logic [7:0] mem [0:32767];
  // Transparent while strobe high, frozen on its fall
  always_latch begin
    if (pads.ale) begin
      lat_q <= pads.ad_out;
    end
  end
  // Top address line left open, so the upper half aliases the lower
  assign a = {pads.high_out[6:0], lat_q};
  // No clock: trailing strobe may reopen the latch as the write ends
  always @(pads.wr_n or pads.ad_out or a) begin
    if (!pads.wr_n) begin
      wbuf = pads.ad_out;
      wadr = a;
    end
  end
  always @(posedge pads.wr_n) begin
    mem[wadr] = wbuf;
  end
  assign mem_oe = !pads.rd_n;
  assign mem_d = mem[a];
endmodule
